// [include/ems_pkg.sv]
// Purpose: shared constants for the external memory strobe sequencer
// Assumes: 32-bit AHB-Lite register bus, word aligned registers
// Notes: all offsets are byte addresses
package ems_pkg;
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_TIMING = 8'h04;
  localparam logic [7:0] OFS_ADDR = 8'h08;
  localparam logic [7:0] OFS_WDATA = 8'h0C;
  localparam logic [7:0] OFS_CMD = 8'h10;
  localparam logic [7:0] OFS_STATUS = 8'h14;
  localparam logic [7:0] OFS_RDATA = 8'h18;
  // ctrl fields
  localparam int CTRL_USE_RDY = 0;
  localparam int CTRL_RDY_MODE = 1;
  localparam int CTRL_X2 = 2;
  localparam int CTRL_W = 3;
  localparam logic [2:0] CTRL_RST = 3'h0;
  // timing fields, four bits each
  localparam int CNT_W = 4;
  localparam int TIM_RD_LEAD = 0;
  localparam int TIM_RD_ACT = 4;
  localparam int TIM_RD_TRAIL = 8;
  localparam int TIM_WR_LEAD = 12;
  localparam int TIM_WR_ACT = 16;
  localparam int TIM_WR_TRAIL = 20;
  localparam int TIM_W = 24;
  localparam logic [23:0] TIM_RST = 24'h111111;
  // cmd fields
  localparam int CMD_START = 0;
  localparam int CMD_WRITE = 1;
  // status fields
  localparam int STAT_BUSY = 0;
  // ahb encodings
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0] HTRANS_SEQ = 2'h3;
  localparam logic HRESP_OKAY = 1'b0;
  // sequencer states
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_ALIGN = 3'b001,
    ST_LEAD = 3'b010,
    ST_ACTIVE = 3'b011,
    ST_TRAIL = 3'b100
  } ems_state_t;
endpackage

// [design/ems_sequencer.sv]
// Purpose: strobe sequencer for a zoned external memory port, AHB-Lite register side
// Assumes: clk is the bus clock, timing_base_clock is the link domain clock
// Notes: timing values are only changed while the sequencer is idle
//
// Function
// R1 - each access starts its lead period on a rising edge of the external clock, after one alignment cycle if needed.
// R2 - during an alignment cycle all strobes and controls stay inactive.
// R3 - with ready use disabled the ready input is ignored and only the programmed counts apply.
// R4 - the address bus keeps the last driven address through inactive and alignment cycles.
// R5 - the zone select goes low with a rising external clock edge at access start.
// R6 - a new address appears with a rising external clock edge at access start.
// R7 - the read strobe may go low on either external clock edge, set by the lead count.
// R8 - the zone select may return high on either external clock edge.
// R9 - for a write, read-not-write goes low with a rising external clock edge at access start.
// R10 - read-not-write may return high on either external clock edge at the end of a write.
// R11 - write data is driven no earlier than the write strobe assertion.
// R12 - write data stays driven through the write trail period.
// R13 - the data bus is released only after read-not-write is back high.
// R14 - the memory holds valid read data until the read strobe is released.
// R15 - lead, active and trail are counted in base clock cycles; the external clock is full or half rate. At full rate the code holds ext_clock_out high.
// R16 - at half rate, changes after an even base count land on rising edges, odd ones on falling.
// R17 - read data is captured on the edge that releases the read strobe.
`timescale 1ns/10ps
module ems_sequencer #(
  parameter int ADDR_W = 19,
  parameter int DATA_W = 16
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic timing_base_clock,
  output logic ext_clock_out,
  output logic zone_select_n,
  output logic read_strobe_n,
  output logic write_strobe_n,
  output logic read_not_write,
  output logic [ADDR_W-1:0] ext_address_bus,
  input wire logic [DATA_W-1:0] ext_data_in,
  output logic [DATA_W-1:0] ext_data_out,
  output logic ext_data_oe,
  input wire logic ext_ready_in
);
  localparam int CW = ems_pkg::CNT_W;

  generate
    if (ADDR_W < 1 || ADDR_W > 32 || DATA_W < 1 || DATA_W > 32) begin : g_chk
      $error("ems_sequencer: ADDR_W and DATA_W must lie in 1..32");
    end
  endgenerate

  // ---------------- bus domain ----------------
  logic [ems_pkg::CTRL_W-1:0] ctrl_q;
  logic [ems_pkg::TIM_W-1:0] timing_q;
  logic [ADDR_W-1:0] addr_reg_q;
  logic [DATA_W-1:0] wdata_reg_q;
  logic cmd_write_q;
  logic busy_q;
  logic start_tgl_q;
  logic [DATA_W-1:0] rdata_reg_q;
  logic wr_pend_q;
  logic [7:0] wr_ofs_q;
  logic [31:0] hrdata_q;
  logic hreadyout_q;
  logic [2:0] done_sync_q;
  logic done_ack_q;
  // link-side results read back here through the done toggle
  logic lk_done_tgl_q, lk_done_tgl_d;
  logic [DATA_W-1:0] lk_rdata_q, lk_rdata_d;

  wire addr_ok = hsel && hready && (htrans == ems_pkg::HTRANS_NONSEQ ||
                 htrans == ems_pkg::HTRANS_SEQ);
  wire rd_take = addr_ok && !hwrite;
  wire wr_take = addr_ok && hwrite;
  wire [7:0] a_ofs = haddr[7:0];
  wire a_hit = (haddr[31:8] == 24'h000000);
  wire done_stable = (done_sync_q[1] == done_sync_q[2]);
  wire done_ev = done_stable && (done_sync_q[2] != done_ack_q);
  wire start_req = wr_pend_q && (wr_ofs_q == ems_pkg::OFS_CMD) &&
                   hwdata[ems_pkg::CMD_START] && !busy_q;
  logic [31:0] rd_mux;

  always_comb begin
    rd_mux = 32'h00000000;
    if (a_hit) begin
      case (a_ofs)
        ems_pkg::OFS_CTRL: rd_mux[ems_pkg::CTRL_W-1:0] = ctrl_q;
        ems_pkg::OFS_TIMING: rd_mux[ems_pkg::TIM_W-1:0] = timing_q;
        ems_pkg::OFS_ADDR: rd_mux[ADDR_W-1:0] = addr_reg_q;
        ems_pkg::OFS_WDATA: rd_mux[DATA_W-1:0] = wdata_reg_q;
        ems_pkg::OFS_CMD: rd_mux[ems_pkg::CMD_WRITE] = cmd_write_q;
        ems_pkg::OFS_STATUS: rd_mux[ems_pkg::STAT_BUSY] = busy_q;
        ems_pkg::OFS_RDATA: rd_mux[DATA_W-1:0] = rdata_reg_q;
        default: rd_mux = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      wr_pend_q <= 1'b0;
      wr_ofs_q <= 8'h00;
      hrdata_q <= 32'h00000000;
      hreadyout_q <= 1'b1;
    end else begin
      wr_pend_q <= wr_take && a_hit;
      wr_ofs_q <= a_ofs;
      hrdata_q <= rd_take ? rd_mux : 32'h00000000;
      hreadyout_q <= 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      ctrl_q <= ems_pkg::CTRL_RST;
      timing_q <= ems_pkg::TIM_RST;
      addr_reg_q <= '0;
      wdata_reg_q <= '0;
      cmd_write_q <= 1'b0;
    end else if (wr_pend_q && !busy_q) begin
      case (wr_ofs_q)
        ems_pkg::OFS_CTRL: ctrl_q <= hwdata[ems_pkg::CTRL_W-1:0];
        ems_pkg::OFS_TIMING: timing_q <= hwdata[ems_pkg::TIM_W-1:0];
        ems_pkg::OFS_ADDR: addr_reg_q <= hwdata[ADDR_W-1:0];
        ems_pkg::OFS_WDATA: wdata_reg_q <= hwdata[DATA_W-1:0];
        ems_pkg::OFS_CMD: cmd_write_q <= hwdata[ems_pkg::CMD_WRITE];
        default: cmd_write_q <= cmd_write_q;
      endcase
    end
  end

  // start handshake out, done toggle back
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      busy_q <= 1'b0;
      start_tgl_q <= 1'b0;
      done_sync_q <= 3'h0;
      done_ack_q <= 1'b0;
      rdata_reg_q <= '0;
    end else begin
      done_sync_q <= {done_sync_q[1:0], lk_done_tgl_q};
      if (start_req) begin
        busy_q <= 1'b1;
        start_tgl_q <= ~start_tgl_q;
      end else if (done_ev) begin
        busy_q <= 1'b0;
      end
      if (done_ev) begin
        done_ack_q <= done_sync_q[2];
        rdata_reg_q <= lk_rdata_q;
      end
    end
  end

  assign hrdata = hrdata_q;
  assign hreadyout = hreadyout_q;
  assign hresp = ems_pkg::HRESP_OKAY;

  // ---------------- link domain ----------------
  logic [2:0] lk_rst_sync_q;
  logic [2:0] lk_start_sync_q;
  logic lk_start_ack_q;
  logic [2:0] rdy_sync_q;
  logic rdy_q;
  logic [ems_pkg::CTRL_W-1:0] ctrl_s1_q;
  logic [ems_pkg::CTRL_W-1:0] ctrl_s2_q;
  logic [ems_pkg::CTRL_W-1:0] ctrl_s3_q;
  logic [ems_pkg::CTRL_W-1:0] lk_ctrl_q;
  ems_pkg::ems_state_t st_q, st_d;
  logic [CW-1:0] cnt_q, cnt_d;
  logic lk_wr_q;
  logic [CW-1:0] lk_lead_q, lk_act_q, lk_trail_q;
  logic xclk_q;
  logic zone_q, zone_d;
  logic rdn_q, rdn_d;
  logic wen_q, wen_d;
  logic rnw_q, rnw_d;
  logic [ADDR_W-1:0] xa_q, xa_d;
  logic [DATA_W-1:0] xd_q, xd_d;
  logic oe_q, oe_d;

  wire lk_rst = !lk_rst_sync_q[2];
  wire lk_start_ev = (lk_start_sync_q[1] == lk_start_sync_q[2]) &&
                     (lk_start_sync_q[2] != lk_start_ack_q);
  wire x2 = lk_ctrl_q[ems_pkg::CTRL_X2];
  wire use_rdy = lk_ctrl_q[ems_pkg::CTRL_USE_RDY];
  wire ready_ok = !use_rdy || rdy_q; // R3
  // next edge rises only while the divided clock is low
  wire need_align = x2 && xclk_q; // R1 R16
  wire [CW-1:0] cfg_lead = cmd_write_q ?
      timing_q[ems_pkg::TIM_WR_LEAD +: CW] : timing_q[ems_pkg::TIM_RD_LEAD +: CW];
  wire [CW-1:0] cfg_act = cmd_write_q ?
      timing_q[ems_pkg::TIM_WR_ACT +: CW] : timing_q[ems_pkg::TIM_RD_ACT +: CW];
  wire [CW-1:0] cfg_trail = cmd_write_q ?
      timing_q[ems_pkg::TIM_WR_TRAIL +: CW] : timing_q[ems_pkg::TIM_RD_TRAIL +: CW];

  function automatic logic [CW-1:0] cnt_load(input logic [CW-1:0] n);
    cnt_load = (n == '0) ? '0 : n - 1'b1;
  endfunction

  always_ff @(posedge timing_base_clock) begin
    lk_rst_sync_q <= {lk_rst_sync_q[1:0], rst_b};
  end

  always_ff @(posedge timing_base_clock) begin
    if (lk_rst) begin
      lk_start_sync_q <= 3'h0;
      rdy_sync_q <= 3'h0;
      rdy_q <= 1'b0;
      ctrl_s1_q <= '0;
      ctrl_s2_q <= '0;
      ctrl_s3_q <= '0;
      lk_ctrl_q <= '0;
    end else begin
      lk_start_sync_q <= {lk_start_sync_q[1:0], start_tgl_q};
      rdy_sync_q <= {rdy_sync_q[1:0], ext_ready_in};
      if (rdy_sync_q[1] == rdy_sync_q[2]) begin
        rdy_q <= rdy_sync_q[2];
      end
      ctrl_s1_q <= ctrl_q;
      ctrl_s2_q <= ctrl_s1_q;
      ctrl_s3_q <= ctrl_s2_q;
      if (ctrl_s2_q == ctrl_s3_q) begin
        lk_ctrl_q <= ctrl_s3_q;
      end
    end
  end

  always_comb begin
    st_d = st_q;
    cnt_d = cnt_q;
    zone_d = zone_q;
    rdn_d = rdn_q;
    wen_d = wen_q;
    rnw_d = rnw_q;
    xa_d = xa_q; // R4
    xd_d = xd_q;
    oe_d = oe_q;
    lk_done_tgl_d = lk_done_tgl_q;
    lk_rdata_d = lk_rdata_q;
    case (st_q)
      ems_pkg::ST_IDLE: begin
        oe_d = 1'b0; // R13
        if (lk_start_ev) begin
          if (need_align) begin
            st_d = ems_pkg::ST_ALIGN; // R1 R2
          end else begin
            // captured copies are not loaded yet: take the live setup
            st_d = ems_pkg::ST_LEAD;
            zone_d = 1'b0; // R5
            rnw_d = !cmd_write_q; // R9
            xa_d = addr_reg_q; // R6
            cnt_d = cnt_load(cfg_lead); // R15
          end
        end
      end
      ems_pkg::ST_ALIGN: begin
        st_d = ems_pkg::ST_LEAD;
        zone_d = 1'b0; // R5
        rnw_d = !lk_wr_q; // R9
        xa_d = addr_reg_q; // R6
        cnt_d = cnt_load(lk_lead_q);
      end
      ems_pkg::ST_LEAD: begin
        if (cnt_q != '0) begin
          cnt_d = cnt_q - 1'b1;
        end else if (lk_act_q == '0) begin
          st_d = (lk_trail_q == '0) ? ems_pkg::ST_IDLE : ems_pkg::ST_TRAIL;
          cnt_d = cnt_load(lk_trail_q);
        end else begin
          st_d = ems_pkg::ST_ACTIVE;
          cnt_d = cnt_load(lk_act_q);
          rdn_d = lk_wr_q; // R7
          wen_d = !lk_wr_q;
          if (lk_wr_q) begin
            oe_d = 1'b1; // R11
            xd_d = wdata_reg_q;
          end
        end
      end
      ems_pkg::ST_ACTIVE: begin
        if (cnt_q != '0) begin
          cnt_d = cnt_q - 1'b1;
        end else if (ready_ok) begin // R3
          rdn_d = 1'b1;
          wen_d = 1'b1;
          if (!lk_wr_q) begin
            lk_rdata_d = ext_data_in; // R17 R14
          end
          st_d = (lk_trail_q == '0) ? ems_pkg::ST_IDLE : ems_pkg::ST_TRAIL;
          cnt_d = cnt_load(lk_trail_q);
        end
      end
      ems_pkg::ST_TRAIL: begin
        // oe held through trail
        if (cnt_q != '0) begin
          cnt_d = cnt_q - 1'b1; // R12
        end else begin
          st_d = ems_pkg::ST_IDLE;
        end
      end
      default: begin
        st_d = ems_pkg::ST_IDLE;
      end
    endcase
    // leaving the access: zone and direction released on whatever phase
    if (st_q != ems_pkg::ST_IDLE && st_q != ems_pkg::ST_ALIGN &&
        st_d == ems_pkg::ST_IDLE) begin
      zone_d = 1'b1; // R8
      rnw_d = 1'b1; // R10
      lk_done_tgl_d = !lk_done_tgl_q;
    end
  end

  always_ff @(posedge timing_base_clock) begin
    if (lk_rst) begin
      st_q <= ems_pkg::ST_IDLE;
      cnt_q <= '0;
      zone_q <= 1'b1;
      rdn_q <= 1'b1;
      wen_q <= 1'b1;
      rnw_q <= 1'b1;
      xa_q <= '0;
      xd_q <= '0;
      oe_q <= 1'b0;
      lk_done_tgl_q <= 1'b0;
      lk_rdata_q <= '0;
      xclk_q <= 1'b0;
    end else begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      zone_q <= zone_d;
      rdn_q <= rdn_d;
      wen_q <= wen_d;
      rnw_q <= rnw_d;
      xa_q <= xa_d;
      xd_q <= xd_d;
      oe_q <= oe_d;
      lk_done_tgl_q <= lk_done_tgl_d;
      lk_rdata_q <= lk_rdata_d;
      xclk_q <= x2 ? !xclk_q : 1'b1; // R15
    end
  end

  // capture the access setup when the start event is seen
  always_ff @(posedge timing_base_clock) begin
    if (lk_rst) begin
      lk_start_ack_q <= 1'b0;
      lk_wr_q <= 1'b0;
      lk_lead_q <= '0;
      lk_act_q <= '0;
      lk_trail_q <= '0;
    end else if (lk_start_ev && st_q == ems_pkg::ST_IDLE) begin
      lk_start_ack_q <= lk_start_sync_q[2];
      lk_wr_q <= cmd_write_q;
      lk_lead_q <= (cfg_lead == '0) ? CW'(1) : cfg_lead;
      lk_act_q <= cfg_act;
      lk_trail_q <= cfg_trail;
    end
  end

  assign ext_clock_out = xclk_q;
  assign zone_select_n = zone_q;
  assign read_strobe_n = rdn_q;
  assign write_strobe_n = wen_q;
  assign read_not_write = rnw_q;
  assign ext_address_bus = xa_q;
  assign ext_data_out = xd_q;
  assign ext_data_oe = oe_q;
endmodule // ems_sequencer

// [tb/ems_sequencer_assertions.sv]
// Purpose: port checker for the strobe sequencer link side
// Assumes: link outputs sampled on timing_base_clock
// Notes: bound into ems_sequencer
`timescale 1ns/10ps
module ems_sequencer_assertions #(
  parameter int ADDR_W = 19,
  parameter int DATA_W = 16
) (
  input wire logic rst_b,
  input wire logic timing_base_clock,
  input wire logic ext_clock_out,
  input wire logic zone_select_n,
  input wire logic read_strobe_n,
  input wire logic write_strobe_n,
  input wire logic read_not_write,
  input wire logic [ADDR_W-1:0] ext_address_bus,
  input wire logic [DATA_W-1:0] ext_data_out,
  input wire logic ext_data_oe
);
  default clocking cb @(posedge timing_base_clock); endclocking
  default disable iff (!rst_b);
  a_start_rise: assert property ($fell(zone_select_n) |-> ext_clock_out)
    else $error("zone select fell off a rising clock edge");
  a_addr_idle: assert property (zone_select_n |-> $stable(ext_address_bus))
    else $error("address moved while idle");
  a_addr_start: assert property ($changed(ext_address_bus) |-> $fell(zone_select_n))
    else $error("address changed outside access start");
  a_rnw_start: assert property ($fell(read_not_write) |-> $fell(zone_select_n))
    else $error("write direction set outside access start");
  a_idle_quiet: assert property (zone_select_n |->
    read_strobe_n && write_strobe_n && read_not_write)
    else $error("control active outside an access");
  a_we_drive: assert property ($rose(ext_data_oe) |-> $fell(write_strobe_n))
    else $error("data driven before write strobe");
  a_data_held: assert property (ext_data_oe && !read_not_write |=>
    ext_data_oe && $stable(ext_data_out))
    else $error("write data dropped early");
  a_oe_release: assert property ($fell(ext_data_oe) |->
    $past(read_not_write) && read_not_write)
    else $error("bus released before direction returned");
  a_acc_bound: assert property ($fell(zone_select_n) |-> ##[1:64] zone_select_n)
    else $error("access did not end");
  c_write: cover property ($fell(write_strobe_n));
  c_rd_fall: cover property ($fell(read_strobe_n) && !ext_clock_out);
  c_start: cover property ($fell(zone_select_n));
endmodule // ems_sequencer_assertions
bind ems_sequencer ems_sequencer_assertions #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) i_chk (
  .rst_b(rst_b), .timing_base_clock(timing_base_clock), .ext_clock_out(ext_clock_out),
  .zone_select_n(zone_select_n), .read_strobe_n(read_strobe_n),
  .write_strobe_n(write_strobe_n), .read_not_write(read_not_write),
  .ext_address_bus(ext_address_bus), .ext_data_out(ext_data_out), .ext_data_oe(ext_data_oe));

// [tb/ems_memory_model.sv]
// Purpose: external memory with programmable ready delay
// Assumes: 16 words, low address bits only
// Notes: undriven bus toggles so stale data never looks valid
`timescale 1ns/10ps
module ems_memory_model (
  input wire logic timing_base_clock,
  input wire logic zone_select_n,
  input wire logic read_strobe_n,
  input wire logic write_strobe_n,
  input wire logic [18:0] ext_address_bus,
  input wire logic [15:0] ext_data_out,
  input wire logic ext_data_oe,
  input wire logic [3:0] wait_cycles,
  output logic [15:0] ext_data_in,
  output logic ext_ready_in
);
  logic [15:0] mem [16];
  logic [15:0] drv = 16'h0000;
  logic [3:0] wcnt = 4'h0;
  always @(posedge timing_base_clock) begin
    if (!write_strobe_n) mem[ext_address_bus[3:0]] <= ext_data_out;
    if (!read_strobe_n) drv <= mem[ext_address_bus[3:0]];
    else drv <= ~drv;
    if (zone_select_n) wcnt <= wait_cycles;
    else if (wcnt != 4'h0) wcnt <= wcnt - 4'h1;
  end
  assign ext_ready_in = (wcnt == 4'h0);
  assign ext_data_in = ext_data_oe ? ext_data_out : drv;
endmodule // ems_memory_model

// [tb/ems_sequencer_tb.sv]
// Purpose: self-checking bench for the strobe sequencer
// Assumes: single AHB-Lite master, memory model on the link
// Notes: link activity is counted in base clock cycles
`timescale 1ns/10ps
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin miscompares++; \
  $display("ERROR %0t got %0h exp %0h", $time, (g), (e)); end end
module ems_sequencer_tb;
  logic clk = 1'b0;
  logic bclk = 1'b0;
  logic rst_b = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic hreadyout, hresp, ext_clock_out, zone_select_n, read_strobe_n, write_strobe_n;
  logic read_not_write, ext_data_oe, ext_ready_in;
  logic [18:0] ext_address_bus;
  logic [15:0] ext_data_in, ext_data_out;
  logic [3:0] wait_cycles = 4'h0;
  int miscompares = 0;
  int n_compared = 0;
  int n_zone = 0, n_strb = 0, n_oe = 0, n_acc = 0;
  logic ck_first = 1'b0, sprev = 1'b1, zprev = 1'b1;
  logic [31:0] rd;
  always #50 clk = ~clk;
  initial begin
    #7;
    forever #24 bclk = ~bclk;
  end
  ems_sequencer i_dut (.clk(clk), .rst_b(rst_b), .hsel(1'b1), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .timing_base_clock(bclk),
    .ext_clock_out(ext_clock_out), .zone_select_n(zone_select_n),
    .read_strobe_n(read_strobe_n), .write_strobe_n(write_strobe_n),
    .read_not_write(read_not_write), .ext_address_bus(ext_address_bus),
    .ext_data_in(ext_data_in), .ext_data_out(ext_data_out), .ext_data_oe(ext_data_oe),
    .ext_ready_in(ext_ready_in));
  ems_memory_model i_mem (.timing_base_clock(bclk), .zone_select_n(zone_select_n),
    .read_strobe_n(read_strobe_n), .write_strobe_n(write_strobe_n),
    .ext_address_bus(ext_address_bus), .ext_data_out(ext_data_out),
    .ext_data_oe(ext_data_oe), .wait_cycles(wait_cycles), .ext_data_in(ext_data_in),
    .ext_ready_in(ext_ready_in));
  always @(posedge bclk) begin
    if (!zone_select_n) n_zone++;
    if (!(read_strobe_n && write_strobe_n)) begin
      if (sprev) ck_first = ext_clock_out;
      n_strb++;
    end
    if (ext_data_oe) n_oe++;
    if (zprev && !zone_select_n) n_acc++;
    sprev = read_strobe_n && write_strobe_n;
    zprev = zone_select_n;
  end
  task automatic ahb(input logic [7:0] a, input logic w, input logic [31:0] wd,
                     output logic [31:0] r);
    @(posedge clk);
    haddr <= {24'h0, a};
    hwrite <= w;
    htrans <= ems_pkg::HTRANS_NONSEQ;
    do @(posedge clk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge clk); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask
  // one access; a second start while busy must be dropped
  task automatic go(input logic w, input logic [2:0] ctl, input logic [23:0] tim,
                    input logic [3:0] a, input logic [15:0] d, input logic [3:0] wt);
    int i;
    wait_cycles <= wt;
    ahb(ems_pkg::OFS_CTRL, 1'b1, {29'h0, ctl}, rd);
    ahb(ems_pkg::OFS_TIMING, 1'b1, {8'h00, tim}, rd);
    ahb(ems_pkg::OFS_ADDR, 1'b1, {28'h0, a}, rd);
    ahb(ems_pkg::OFS_WDATA, 1'b1, {16'h0, d}, rd);
    n_zone = 0;
    n_strb = 0;
    n_oe = 0;
    n_acc = 0;
    ahb(ems_pkg::OFS_CMD, 1'b1, {30'h0, w, 1'b1}, rd);
    ahb(ems_pkg::OFS_CMD, 1'b1, {30'h0, w, 1'b1}, rd);
    i = 0;
    do begin
      ahb(ems_pkg::OFS_STATUS, 1'b0, 32'h0, rd);
      i++;
    end while (rd[0] !== 1'b0 && i < 300);
    `CHK(rd[0], 1'b0)
    `CHK(n_acc, 1)
    `CHK(ext_address_bus, {15'h0, a})
    ahb(ems_pkg::OFS_RDATA, 1'b0, 32'h0, rd);
  endtask
  task automatic t_regs;
    ahb(ems_pkg::OFS_CTRL, 1'b0, 32'h0, rd);
    `CHK(rd, 32'h0000_0000)
    ahb(ems_pkg::OFS_TIMING, 1'b0, 32'h0, rd);
    `CHK(rd, 32'h0011_1111)
    ahb(8'h40, 1'b1, 32'hFFFF_FFFF, rd);
    ahb(8'h40, 1'b0, 32'h0, rd);
    `CHK(rd, 32'h0000_0000)
  endtask
  task automatic t_write;
    go(1'b1, 3'h0, 24'h232121, 4'h5, 16'hA5C3, 4'h0);
    `CHK(n_zone, 7)
    `CHK(n_strb, 3)
    `CHK(n_oe, 6)
  endtask
  // ready input held low must not stretch the access
  task automatic t_read;
    go(1'b0, 3'h0, 24'h232121, 4'h5, 16'h0000, 4'h8);
    `CHK(n_zone, 4)
    `CHK(n_strb, 2)
    `CHK(rd[15:0], 16'hA5C3)
  endtask
  task automatic t_half;
    for (int l = 1; l <= 2; l++) begin
      go(1'b0, 3'h4, 24'h232120 | 24'(l), 4'h5, 16'h0000, 4'h0);
      `CHK(n_zone, l + 3)
      `CHK(ck_first, (l == 2))
      `CHK(rd[15:0], 16'hA5C3)
    end
  endtask
  task automatic t_ready;
    go(1'b0, 3'h1, 24'h232121, 4'h5, 16'h0000, 4'h8);
    `CHK(n_strb > 2, 1'b1)
    `CHK(rd[15:0], 16'hA5C3)
  endtask
  task automatic give_verdict;
    $display("compared %0d mismatched %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge clk);
    rst_b <= 1'b1;
    repeat (40) @(posedge clk);
    t_regs;
    t_write;
    t_read;
    t_half;
    t_ready;
    give_verdict;
  end
  initial begin
    #3000000;
    miscompares++;
    give_verdict;
  end
endmodule // ems_sequencer_tb
